// *** hw/lct_consts.svh ***
`ifndef LCT_CONSTS_SVH
`define LCT_CONSTS_SVH
`define LCT_NCH 18
`define LCT_AW 16
`define LCT_DEPTH 65536
`define LCT_NLVL 4
`define LCT_OFF_CTRL 8'h00
`define LCT_OFF_STAT 8'h04
`define LCT_OFF_RATE 8'h08
`define LCT_OFF_TADDR 8'h0c
`define LCT_OFF_WPTR 8'h10
`define LCT_OFF_RADDR 8'h14
`define LCT_OFF_RDATA 8'h18
`define LCT_OFF_ISTAT 8'h1c
`define LCT_OFF_ICLR 8'h20
`define LCT_OFF_IEN 8'h24
`define LCT_OFF_LVL 8'h40
`define LCT_CTRL_START 0
`define LCT_CTRL_EXT 1
`define LCT_CTRL_QEN 2
`define LCT_CTRL_PLO 4
`define LCT_CTRL_PHI 5
`define LCT_CTRL_NLO 8
`define LCT_CTRL_NHI 9
`define LCT_PLACE_PRE 2'h0
`define LCT_PLACE_POST 2'h1
`define LCT_POST_PRE 16'h0010
`define LCT_POST_MIX 16'h8000
`define LCT_POST_POST 16'hfff0
`define LCT_IRQ_TRIG 0
`define LCT_IRQ_DONE 1
`define LCT_RESP_OK 2'h0
`define LCT_RESP_ERR 2'h2
`endif

// *** hw/lct_pkg.sv ***
package lct_pkg;
    typedef enum logic [1:0] {LCT_IDLE, LCT_ARMED, LCT_POST, LCT_DONE} lct_state_t;
    typedef struct packed {
        logic [17:0] care;
        logic [17:0] val;
        logic [17:0] rise;
        logic [17:0] fall;
        logic [15:0] count;
    } lct_lvl_t;
    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } lct_axi_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } lct_axi_rsp_t;
endpackage

// *** hw/lct_capture.sv ***
`timescale 1ns/100ps
`include "lct_consts.svh"
// Summary of operation
// - Sample clock comes from an internal rate divider or the target's external clock.
// - In external mode channels are sampled only on the external clock's rising edge.
// - Every channel is stored as one bit per sample.
// - Samples go to consecutive memory words; the write pointer wraps as a ring.
// - Before trigger, a full memory keeps filling, overwriting the oldest sample.
// - Trigger placement selects mostly pre, mostly post, or mixed samples.
// - While the qualifier is false no sample is written.
// - Don't-care channels are ignored by the level comparison; their rise and fall bits still apply.
// - Trigger recognizes edges, level combinations and a count of stored samples.
// - Edges are found between successive samples, not from static levels.
// - Host reads acquisition memory after the capture finishes.
// - After trigger, storing continues for the post-fill count, then stops.
// - Eighteen data channels plus one external clock input.
// - Memory holds 64K samples per channel.
// - Per-channel rising, falling or either edge; up to four trigger levels.
module lct_capture (
    input wire logic aclk,
    input wire logic aresetn,
    input wire lct_pkg::lct_axi_req_t axi_req,
    output lct_pkg::lct_axi_rsp_t axi_rsp,
    input wire logic [`LCT_NCH-1:0] chan_in,
    input wire logic ext_clk_in,
    input wire logic qual_in,
    output logic irq
);
    import lct_pkg::*;

    // Register map, one aligned 32-bit word each, data in the low bits.
    // Offset 00 is the control word.
    // Its bit 0 starts a run; it acts once and always reads back as zero.
    // Its bit 1 selects the target's clock instead of the internal divider.
    // Its bit 2 lets the qualifier pin gate the sample tick.
    // Its bits 5:4 choose the trigger placement in the ring.
    // Its bits 9:8 hold the number of trigger levels minus one.
    // Offset 04 is the status word: running (armed or post fill), triggered and done in bits 0 to 2.
    // Offset 08 sets the internal tick period, which is the value plus one clocks.
    // Offset 0c holds the ring address at which the trigger sample was written.
    // Offset 10 shows the current write pointer of the ring.
    // Offset 14 selects the ring word that offset 18 returns.
    // Offset 18 returns the selected ring word, or zero while a run is active.
    // Offset 1c holds the sticky event bits: trigger in bit 0, done in bit 1.
    // Offset 20 clears event bits where a one is written.
    // Offset 24 enables the event bits onto the interrupt line.
    // Each trigger level takes a block of five words from offset 40 upward.
    // The blocks stand 20h apart, so level three starts at offset a0.
    // Within a block the words are care, value, rise, fall and count.
    // Any other offset, and any unaligned one, answers with a slave error.
    // A refused write changes nothing, and a refused read returns zero.

    // Placement and post fill.
    // Placement zero stops soon after the trigger, so most of the ring is history.
    // Placement one fills almost the whole ring after the trigger.
    // Placements two and three keep half of each.
    // The post counter ends the run when it equals the chosen value.
    // That is one more sample than the value after the trigger sample.
    // A trade-off: the fill lengths are fixed to keep the host interface small.

    // Trigger levels.
    // A level matches when every cared channel equals its value bit.
    // Channels with a rise or fall bit set are judged as edges instead.
    // Setting both rise and fall on a channel accepts either edge.
    // Edges are judged against the previous stored sample, not the previous clock.
    // A level with a nonzero count waits that many further samples, then advances.
    // The wait does not look at the pattern again; it only counts samples.
    // Only written samples move the sequencer, so a gated tick stalls it too.
    // The last level, chosen in the control word, fires the trigger.

    // Limitations a user should know.
    // The target's clock must stay high and low for at least two clocks each.
    // Slower pins are fine, but faster ones will lose edges in the synchroniser.
    // The qualifier is synchronised the same way and so lags its pin a little.
    // A new start aborts any run in progress and rearms from the first level.
    // The ring is not cleared by a start, so old words stay until overwritten.
    // The host must wait for the done bit before reading the ring.
    // Reading the ring during a run would race the writer, so it returns zero.
    // Readout data stands two clocks after the read address is written.

    // Bus behaviour.
    // Address and data of a write may come in either order or together.
    // The write answer stands one clock after the later of the two is taken.
    // A read is answered one clock after its address is taken.
    // Only one write and one read are in flight at any time.
    // The ready lines drop for a clock after each offer so a held request is safe.

    // Pin synchronisers; logic reads the second stage, and the external clock's third stage for edge detection.
    logic [`LCT_NCH-1:0] ch_s1_r, ch_s2_r;
    logic ec_s1_r, ec_s2_r, ec_s3_r, q_s1_r, q_s2_r;
    always_ff @(posedge aclk) begin
        ch_s1_r <= chan_in;
        ch_s2_r <= ch_s1_r;
        ec_s1_r <= ext_clk_in;
        ec_s2_r <= ec_s1_r;
        ec_s3_r <= ec_s2_r;
        q_s1_r <= qual_in;
        q_s2_r <= q_s1_r;
    end

    // Software state.
    logic ext_mode_r, qual_en_r;
    logic [1:0] place_r;
    logic [1:0] nlvl_r;
    logic [31:0] rate_r;
    logic [`LCT_AW-1:0] raddr_r, taddr_r, wptr_r;
    logic [1:0] istat_r, ien_r;
    lct_lvl_t lvl_r [`LCT_NLVL];
    lct_state_t state_r;
    logic [1:0] stage_r;
    logic [15:0] wait_r, post_r;
    logic [31:0] div_r;
    logic [`LCT_NCH-1:0] prev_r;
    logic [`LCT_NCH-1:0] mem [`LCT_DEPTH];
    logic [`LCT_NCH-1:0] mem_q_r;

    // Level and edge comparison of one trigger level.
    function automatic logic lvl_match(input lct_lvl_t l, input logic [17:0] cur, input logic [17:0] prv);
        logic [17:0] edg;
        logic lv_ok, ed_ok;
        edg = l.rise | l.fall;
        lv_ok = &(~l.care | edg | ~(cur ^ l.val));
        ed_ok = &(~edg | (l.rise & ~prv & cur) | (l.fall & prv & ~cur));
        return lv_ok & ed_ok;
    endfunction

    // Sample tick: divider in timing mode, external edge in state mode, gated by the qualifier.
    wire div_hit = (div_r == rate_r);
    wire ext_edge = ec_s2_r & ~ec_s3_r;
    wire raw_tick = ext_mode_r ? ext_edge : div_hit;
    wire qual_ok = ~qual_en_r | q_s2_r;
    wire tick = raw_tick & qual_ok;
    wire running = (state_r == LCT_ARMED) || (state_r == LCT_POST);
    wire wr_smp = tick & running;

    // Trigger sequencer decisions for the current sample.
    wire cur_hit = lvl_match(lvl_r[stage_r], ch_s2_r, prev_r);
    wire lvl_done = (wait_r == 16'h0001) || ((wait_r == 16'h0000) && cur_hit && (lvl_r[stage_r].count == 16'h0000));
    wire start_wait = (wait_r == 16'h0000) && cur_hit && (lvl_r[stage_r].count != 16'h0000);
    wire trig_now = wr_smp && (state_r == LCT_ARMED) && lvl_done && (stage_r == nlvl_r);
    wire [15:0] post_target = (place_r == `LCT_PLACE_PRE) ? `LCT_POST_PRE :
                              (place_r == `LCT_PLACE_POST) ? `LCT_POST_POST : `LCT_POST_MIX;
    wire fill_end = wr_smp && (state_r == LCT_POST) && (post_r == post_target);

    // AXI write decode.
    logic aw_got_r, w_got_r, bvalid_r, arready_r, rvalid_r, awready_r, wready_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [1:0] bresp_r, rresp_r;
    wire aw_hs = axi_req.awvalid & awready_r;
    wire w_hs = axi_req.wvalid & wready_r;
    wire aw_now = aw_got_r | aw_hs;
    wire w_now = w_got_r | w_hs;
    wire [7:0] waddr = aw_got_r ? awaddr_r : axi_req.awaddr;
    wire [31:0] wdat = w_got_r ? wdata_r : axi_req.wdata;
    wire do_wr = aw_now & w_now & ~bvalid_r;
    wire wr_lvl = (waddr >= `LCT_OFF_LVL) && (waddr < 8'hc0) && (waddr[4:2] < 3'h5);
    wire wr_map = wr_lvl || (waddr <= `LCT_OFF_IEN && waddr != `LCT_OFF_STAT && waddr != `LCT_OFF_TADDR
                  && waddr != `LCT_OFF_WPTR && waddr != `LCT_OFF_RDATA && waddr != `LCT_OFF_ISTAT);
    wire wr_ok = do_wr & wr_map & (waddr[1:0] == 2'h0);
    wire wr_ctrl = wr_ok && (waddr == `LCT_OFF_CTRL);
    wire start = wr_ctrl && wdat[`LCT_CTRL_START];
    wire [1:0] wr_li = waddr[6:5] - 2'h2;
    wire [2:0] wr_lf = waddr[4:2];

    // AXI read decode.
    wire ar_hs = axi_req.arvalid & arready_r;
    wire [7:0] ra = axi_req.araddr;
    wire [1:0] rd_li = ra[6:5] - 2'h2;
    wire rd_lvl = (ra >= `LCT_OFF_LVL) && (ra < 8'hc0) && (ra[4:2] < 3'h5);
    wire [31:0] lvl_rd = (ra[4:2] == 3'h0) ? {14'h0, lvl_r[rd_li].care} :
                         (ra[4:2] == 3'h1) ? {14'h0, lvl_r[rd_li].val} :
                         (ra[4:2] == 3'h2) ? {14'h0, lvl_r[rd_li].rise} :
                         (ra[4:2] == 3'h3) ? {14'h0, lvl_r[rd_li].fall} : {16'h0, lvl_r[rd_li].count};
    wire [31:0] stat_word = {29'h0, state_r == LCT_DONE, state_r == LCT_POST || state_r == LCT_DONE,
                             running};
    wire [31:0] rd_mux = rd_lvl ? lvl_rd :
        (ra == `LCT_OFF_CTRL) ? {22'h0, nlvl_r, 2'h0, place_r, 1'b0, qual_en_r, ext_mode_r, 1'b0} :
        (ra == `LCT_OFF_STAT) ? stat_word :
        (ra == `LCT_OFF_RATE) ? rate_r :
        (ra == `LCT_OFF_TADDR) ? {16'h0, taddr_r} :
        (ra == `LCT_OFF_WPTR) ? {16'h0, wptr_r} :
        (ra == `LCT_OFF_RADDR) ? {16'h0, raddr_r} :
        (ra == `LCT_OFF_RDATA) ? (running ? 32'h0 : {14'h0, mem_q_r}) :
        (ra == `LCT_OFF_ISTAT) ? {30'h0, istat_r} :
        (ra == `LCT_OFF_IEN) ? {30'h0, ien_r} : 32'h0;
    wire rd_map = rd_lvl || ((ra <= `LCT_OFF_IEN) && (ra != `LCT_OFF_ICLR));
    wire rd_ok = rd_map & (ra[1:0] == 2'h0);

    // Write channel handshake; address and data are taken in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `LCT_RESP_OK;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0;
        end else begin
            if (aw_hs) awaddr_r <= axi_req.awaddr;
            if (w_hs) wdata_r <= axi_req.wdata;
            aw_got_r <= aw_now & ~do_wr;
            w_got_r <= w_now & ~do_wr;
            awready_r <= ~aw_now & ~bvalid_r & ~awready_r;
            wready_r <= ~w_now & ~bvalid_r & ~wready_r;
            if (do_wr) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_ok ? `LCT_RESP_OK : `LCT_RESP_ERR;
            end else if (bvalid_r && axi_req.bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read channel; one read outstanding, answered the cycle after acceptance.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= `LCT_RESP_OK;
        end else begin
            arready_r <= ~rvalid_r & ~arready_r & ~ar_hs;
            if (ar_hs) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_ok ? rd_mux : 32'h0;
                rresp_r <= rd_ok ? `LCT_RESP_OK : `LCT_RESP_ERR;
            end else if (rvalid_r && axi_req.rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Configuration registers written by software.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_mode_r <= 1'b0;
            qual_en_r <= 1'b0;
            place_r <= 2'h0;
            nlvl_r <= 2'h0;
            rate_r <= 32'h0;
            raddr_r <= 16'h0;
            ien_r <= 2'h0;
            for (int i = 0; i < `LCT_NLVL; i++) lvl_r[i] <= '0;
        end else if (wr_ok) begin
            if (wr_ctrl) begin
                ext_mode_r <= wdat[`LCT_CTRL_EXT];
                qual_en_r <= wdat[`LCT_CTRL_QEN];
                place_r <= wdat[`LCT_CTRL_PHI:`LCT_CTRL_PLO];
                nlvl_r <= wdat[`LCT_CTRL_NHI:`LCT_CTRL_NLO];
            end
            if (waddr == `LCT_OFF_RATE) rate_r <= wdat;
            if (waddr == `LCT_OFF_RADDR) raddr_r <= wdat[15:0];
            if (waddr == `LCT_OFF_IEN) ien_r <= wdat[1:0];
            if (wr_lvl && wr_lf == 3'h0) lvl_r[wr_li].care <= wdat[17:0];
            if (wr_lvl && wr_lf == 3'h1) lvl_r[wr_li].val <= wdat[17:0];
            if (wr_lvl && wr_lf == 3'h2) lvl_r[wr_li].rise <= wdat[17:0];
            if (wr_lvl && wr_lf == 3'h3) lvl_r[wr_li].fall <= wdat[17:0];
            if (wr_lvl && wr_lf == 3'h4) lvl_r[wr_li].count <= wdat[15:0];
        end
    end

    // Internal sample-rate divider; free running so the tick period is rate + 1 clocks.
    always_ff @(posedge aclk) begin
        if (!aresetn || div_hit) div_r <= 32'h0;
        else div_r <= div_r + 32'h1;
    end

    // Ring memory write and registered readout port.
    always_ff @(posedge aclk) begin
        if (wr_smp) mem[wptr_r] <= ch_s2_r;
        mem_q_r <= mem[raddr_r];
    end

    // Capture state machine and trigger sequencer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= LCT_IDLE;
            stage_r <= 2'h0;
            wait_r <= 16'h0;
            post_r <= 16'h0;
            wptr_r <= 16'h0;
            taddr_r <= 16'h0;
            prev_r <= '0;
        end else if (start) begin
            // A new start aborts any run and rearms from the first level.
            state_r <= LCT_ARMED;
            stage_r <= 2'h0;
            wait_r <= 16'h0;
            post_r <= 16'h0;
            wptr_r <= 16'h0;
            prev_r <= ch_s2_r;
        end else if (wr_smp) begin
            prev_r <= ch_s2_r;
            wptr_r <= wptr_r + 16'h1;
            unique case (state_r)
                LCT_ARMED: begin
                    if (wait_r != 16'h0) wait_r <= wait_r - 16'h1;
                    else if (start_wait) wait_r <= lvl_r[stage_r].count;
                    if (trig_now) begin
                        state_r <= LCT_POST;
                        taddr_r <= wptr_r;
                    end else if (lvl_done) begin
                        stage_r <= stage_r + 2'h1;
                    end
                end
                LCT_POST: begin
                    post_r <= post_r + 16'h1;
                    if (fill_end) state_r <= LCT_DONE;
                end
                LCT_IDLE, LCT_DONE: begin
                end
            endcase
        end
    end

    // Sticky interrupt status; a new event wins over a clear in the same cycle.
    wire [1:0] ev = {fill_end, trig_now};
    wire [1:0] clr = (wr_ok && waddr == `LCT_OFF_ICLR) ? wdat[1:0] : 2'h0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_r <= 2'h0;
            irq <= 1'b0;
        end else begin
            istat_r <= (istat_r & ~clr) | ev;
            irq <= |(((istat_r & ~clr) | ev) & ien_r);
        end
    end

    assign axi_rsp = '{awready: awready_r, wready: wready_r, bresp: bresp_r, bvalid: bvalid_r,
                       arready: arready_r, rdata: rdata_r, rresp: rresp_r, rvalid: rvalid_r};
endmodule // lct_capture

// *** dv/lct_capture_checker.sv ***
`timescale 1ns/100ps
`include "lct_consts.svh"
// Watches the register bus and the interrupt line of the capture core.
module lct_capture_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire lct_pkg::lct_axi_req_t axi_req,
    input wire lct_pkg::lct_axi_rsp_t axi_rsp,
    input wire logic [`LCT_NCH-1:0] chan_in,
    input wire logic ext_clk_in,
    input wire logic qual_in,
    input wire logic irq
);
    import lct_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Address and data taken together is the fast write path.
    sequence s_wr_taken;
        axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    endsequence
    sequence s_rd_taken;
        axi_req.arvalid && axi_rsp.arready;
    endsequence
    // The first edge after release still shows the quiet reset state.
    AST_RST_QUIET: assert property (
        $rose(aresetn) |-> !irq && !axi_rsp.bvalid && !axi_rsp.rvalid) else $error("outputs busy after reset");
    AST_WR_ANSWER: assert property (
        s_wr_taken |=> axi_rsp.bvalid) else $error("write response not one cycle after accept");
    AST_RD_ANSWER: assert property (
        s_rd_taken |=> axi_rsp.rvalid) else $error("read data not one cycle after accept");
    AST_B_HOLD: assert property (
        axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("bvalid dropped");
    AST_R_HOLD: assert property (
        axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("rdata moved");
    AST_B_DROP: assert property (
        axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid) else $error("bvalid stayed after handshake");
    AST_RD_ONE: assert property (
        axi_rsp.rvalid |-> !axi_rsp.arready) else $error("second read accepted while one pending");
    AST_ERR_ZERO: assert property (
        axi_rsp.rvalid && axi_rsp.rresp == `LCT_RESP_ERR |-> axi_rsp.rdata == 32'h0) else $error("error read not zero");
endmodule // lct_capture_checker
bind lct_capture lct_capture_checker i_chk (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .chan_in(chan_in), .ext_clk_in(ext_clk_in), .qual_in(qual_in), .irq(irq));

// *** dv/lct_target_model.sv ***
`timescale 1ns/100ps
`include "lct_consts.svh"
// Target board: eighteen channels, a burst-only sample clock and the qualifier line.
module lct_target_model (
    input wire logic aclk,
    input wire logic [`LCT_NCH-1:0] pat,
    input wire logic ext_run,
    input wire logic qual_lvl,
    output logic [`LCT_NCH-1:0] chan_in,
    output logic ext_clk_in,
    output logic qual_in
);
    logic [2:0] cnt_r = 3'h0;
    // Three cycles low, three high, so the pod's synchroniser sees both phases.
    always_ff @(posedge aclk) begin
        cnt_r <= (!ext_run || cnt_r == 3'h5) ? 3'h0 : cnt_r + 3'h1;
    end
    // The clock stands low outside a burst, as a gated target clock would.
    assign ext_clk_in = ext_run && cnt_r >= 3'h3;
    assign chan_in = pat;
    assign qual_in = qual_lvl;
endmodule // lct_target_model

// *** dv/lct_capture_tb.sv ***
`timescale 1ns/100ps
`include "lct_consts.svh"
module lct_capture_tb;
    import lct_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    lct_axi_req_t req = '0;
    lct_axi_rsp_t rsp;
    logic [`LCT_NCH-1:0] pat = 18'h2aaaa;
    logic ext_run = 1'b0;
    logic qual_lvl = 1'b1;
    logic [`LCT_NCH-1:0] chan;
    logic ext_clk, qual, irq;
    logic [31:0] rv, ta;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    // Address, write value, expected read-back and response; narrow fields read back truncated.
    localparam logic [73:0] ROWS [9] = '{
        {`LCT_OFF_RATE, 32'h5, 32'h5, `LCT_RESP_OK}, {`LCT_OFF_IEN, 32'hffffffff, 32'h3, `LCT_RESP_OK},
        {8'h60, 32'hffffffff, 32'h3ffff, `LCT_RESP_OK}, {8'h70, 32'hffffffff, 32'hffff, `LCT_RESP_OK},
        {8'hac, 32'h1, 32'h1, `LCT_RESP_OK}, {`LCT_OFF_RADDR, 32'hffffffff, 32'hffff, `LCT_RESP_OK},
        {`LCT_OFF_CTRL, 32'h322, 32'h322, `LCT_RESP_OK}, {8'h30, 32'h1, 32'h0, `LCT_RESP_ERR},
        {8'h02, 32'h1, 32'h0, `LCT_RESP_ERR}};
    always #10 aclk = ~aclk;
    lct_capture i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .chan_in(chan),
        .ext_clk_in(ext_clk), .qual_in(qual), .irq(irq));
    lct_target_model i_tgt (.aclk(aclk), .pat(pat), .ext_run(ext_run), .qual_lvl(qual_lvl),
        .chan_in(chan), .ext_clk_in(ext_clk), .qual_in(qual));
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Each bus task starts one edge on, so a release and a new request never share a time step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (rsp.awready === 1'b1)
                aw_ok = 1'b1;
            if (rsp.wready === 1'b1)
                w_ok = 1'b1;
            req.awvalid <= !aw_ok;
            req.wvalid <= !w_ok;
        end
        do @(posedge aclk); while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        cmp("bresp", {30'h0, er}, {30'h0, rsp.bresp});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do @(posedge aclk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge aclk); while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        d = rsp.rdata;
        cmp("rresp", {30'h0, er}, {30'h0, rsp.rresp});
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        rd(a, rv, `LCT_RESP_OK);
        cmp(n, e, rv);
    endtask
    task automatic burst();
        ext_run <= 1'b1;
        repeat (30) @(posedge aclk);
        ext_run <= 1'b0;
    endtask
    // The whole run is a few hundred cycles; the ceiling only catches a stuck handshake or a trigger that never fires.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cmp("irq idle", 32'h0, {31'h0, irq});
        rc("status idle", `LCT_OFF_STAT, 32'h0);
        foreach (ROWS[i]) begin
            wr(ROWS[i][73:66], ROWS[i][65:34], ROWS[i][1:0]);
            rd(ROWS[i][73:66], rv, ROWS[i][1:0]);
            cmp("row read", ROWS[i][33:2], rv);
        end
        // Five target clocks with the qualifier low, then five with it high; internal ticks must not count.
        qual_lvl <= 1'b0;
        wr(`LCT_OFF_CTRL, 32'h7, `LCT_RESP_OK);
        burst();
        rc("wptr gated", `LCT_OFF_WPTR, 32'h0);
        qual_lvl <= 1'b1;
        repeat (4) @(posedge aclk);
        burst();
        rc("wptr ext", `LCT_OFF_WPTR, 32'h5);
        // Trigger on channel 0 high only; the other channels are left out of the pattern.
        wr(`LCT_OFF_LVL, 32'h1, `LCT_RESP_OK);
        wr(8'h44, 32'h1, `LCT_RESP_OK);
        wr(8'h50, 32'h0, `LCT_RESP_OK);
        wr(`LCT_OFF_ICLR, 32'h3, `LCT_RESP_OK);
        wr(`LCT_OFF_CTRL, 32'h1, `LCT_RESP_OK);
        repeat (60) @(posedge aclk);
        pat <= 18'h2aaab;
        while (irq !== 1'b1) @(posedge aclk);
        rv = 32'h0;
        while (rv[2] !== 1'b1) rd(`LCT_OFF_STAT, rv, `LCT_RESP_OK);
        cmp("status done", 32'h6, rv);
        rc("istat", `LCT_OFF_ISTAT, 32'h3);
        cmp("irq set", 32'h1, {31'h0, irq});
        rd(`LCT_OFF_TADDR, ta, `LCT_RESP_OK);
        rd(`LCT_OFF_WPTR, rv, `LCT_RESP_OK);
        cmp("post fill", 32'd18, (rv - ta) & 32'hffff);
        wr(`LCT_OFF_RADDR, ta, `LCT_RESP_OK);
        rc("trig sample", `LCT_OFF_RDATA, 32'h2aaab);
        wr(`LCT_OFF_RADDR, (ta - 32'h1) & 32'hffff, `LCT_RESP_OK);
        rc("prev sample", `LCT_OFF_RDATA, 32'h2aaaa);
        wr(`LCT_OFF_ICLR, 32'h3, `LCT_RESP_OK);
        rc("istat clear", `LCT_OFF_ISTAT, 32'h0);
        cmp("irq clear", 32'h0, {31'h0, irq});
        close_out();
    end
endmodule // lct_capture_tb
